// *** fsr_pkg.sv ***
// constants for the fault status readback block
// What this block does
// - read-config command 101 returns the ten-bit config word on output bits 9:0
// - read-error command 100 returns the fault status word
// - bit 9 flags an output fault that was latched and has since gone
// - bit 8 sets after output current over limit for more than 260 ms
// - bit 7 sets after output voltage near a rail, no short, over 260 ms
// - bit 6 sets on the overtemperature indication
// - bit 5 sets when a supply enters the brownout limits
// - reporting state steps only on completed serial reads
// - a new fault asserts the interrupt and latches its flag
// - first status read releases the interrupt and shows the active flags
// - second status read still shows the fault, then clears the word
// - only open load or short may set the intermittent flag
// - open load or short gone before first read shows its flag plus intermittent
// - a fault seen again after an all-clear read fires the interrupt again
// - an unresolved reported fault does not fire the interrupt again
// - a different fault type fires the interrupt despite an earlier one
// - a read after clearing shows the fault again while it persists
package fsr_pkg;
    localparam int          CLK_HZ      = 25_000_000;
    localparam int          FILT_MS     = 260;
    localparam int          FILT_CYC    = (CLK_HZ / 1000) * FILT_MS;
    localparam int          FILT_CNT_W  = 23;
    localparam int          FRAME_BITS  = 16;
    localparam int          CMD_LO      = 11;
    localparam int          CMD_AT      = FRAME_BITS - CMD_LO;
    localparam int          DATA_W      = 10;
    localparam int          NUM_FLT     = 4;
    localparam int          FLAG_LO     = 5;
    localparam int          BIT_INTERM  = 9;
    localparam int          IDX_BROWN   = 0;
    localparam int          IDX_OTEMP   = 1;
    localparam int          IDX_OPEN    = 2;
    localparam int          IDX_SHORT   = 3;
    localparam logic [3:0]  OUT_FLT_MASK = 4'hC;
    localparam logic [2:0]  CMD_RD_ERR  = 3'h4;
    localparam logic [2:0]  CMD_RD_CFG  = 3'h5;
    localparam logic [4:0]  RSVD_BITS   = 5'h00;

    typedef enum logic [1:0] {
        FSR_IDLE = 2'b01,
        FSR_ONE  = 2'b10
    } fsr_rd_state_t;
endpackage : fsr_pkg

// *** fsr_qual.sv ***
// persistence filter for an analog fault comparator
`timescale 1ns/1ps
module fsr_qual #(
    parameter int CNT_W = 23,
    parameter int LIMIT = 6_500_000
) (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    input  wire logic raw_i,
    output logic      hit_o
);
    if (LIMIT < 1 || LIMIT >= (2 ** CNT_W))
    begin : g_bad_limit
        $error("fsr_qual: LIMIT does not fit CNT_W");
    end

    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             hit_r;
    logic             hit_nxt;

    // hit only once the condition outlasts the limit
    always_comb
    begin
        cnt_nxt = cnt_r;
        hit_nxt = hit_r;
        if (!raw_i)
        begin
            cnt_nxt = '0;
            hit_nxt = 1'b0;
        end
        else if (cnt_r == CNT_W'(LIMIT))
            hit_nxt = 1'b1;
        else
            cnt_nxt = cnt_r + CNT_W'(1);
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            cnt_r <= '0;
            hit_r <= 1'b0;
        end
        else if (ce_i)
        begin
            cnt_r <= cnt_nxt;
            hit_r <= hit_nxt;
        end
    end

    assign hit_o = hit_r;
endmodule : fsr_qual

// *** fsr_spi.sv ***
// serial slave: command capture and readback shifter
`timescale 1ns/1ps
module fsr_spi #(
    parameter int FRAME_BITS = 16,
    parameter int DATA_W     = 10,
    parameter int CMD_AT     = 5
) (
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    input  wire logic              ce_i,
    input  wire logic              cs_n_i,
    input  wire logic              sclk_i,
    input  wire logic              din_i,
    input  wire logic [DATA_W-1:0] ld_data_i,
    output logic                   cmd_stb_o,
    output logic [2:0]             cmd_o,
    output logic                   frame_done_o,
    output logic                   dout_o
);
    localparam int CW = $clog2(FRAME_BITS + 1);

    if (CMD_AT < 3 || CMD_AT + DATA_W > FRAME_BITS)
    begin : g_bad_frame
        $error("fsr_spi: frame too short for command and data");
    end

    logic          sclk_q_r, sclk_q_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [1:0]    rx_r, rx_nxt;
    logic [DATA_W:0] sh_r, sh_nxt;
    logic          dout_r, dout_nxt;
    logic          stb_r, stb_nxt;
    logic [2:0]    cmd_r, cmd_nxt;
    logic          done_r, done_nxt;
    logic          rise;
    logic          fall;

    assign rise = !cs_n_i && sclk_i && !sclk_q_r;
    assign fall = !cs_n_i && !sclk_i && sclk_q_r;

    // mode 0: sample on rising edge, shift out on falling edge
    always_comb
    begin
        sclk_q_nxt = sclk_i;
        cnt_nxt    = cnt_r;
        rx_nxt     = rx_r;
        sh_nxt     = sh_r;
        dout_nxt   = dout_r;
        stb_nxt    = 1'b0;
        cmd_nxt    = cmd_r;
        done_nxt   = 1'b0;
        if (cs_n_i)
        begin
            done_nxt = (cnt_r == CW'(FRAME_BITS));
            cnt_nxt  = '0;
            sh_nxt   = '0;
            dout_nxt = 1'b0;
        end
        else
        begin
            if (rise)
            begin
                rx_nxt = {rx_r[0], din_i};
                if (cnt_r != CW'(FRAME_BITS))
                    cnt_nxt = cnt_r + CW'(1);
                if (cnt_r == CW'(CMD_AT - 1))
                begin
                    stb_nxt = 1'b1;
                    cmd_nxt = {rx_r, din_i};
                end
            end
            if (stb_r)
                sh_nxt = {1'b0, ld_data_i};
            else if (fall)
            begin
                dout_nxt = sh_r[DATA_W];
                sh_nxt   = {sh_r[DATA_W-1:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            sclk_q_r <= 1'b0;
            cnt_r    <= '0;
            rx_r     <= '0;
            sh_r     <= '0;
            dout_r   <= 1'b0;
            stb_r    <= 1'b0;
            cmd_r    <= '0;
            done_r   <= 1'b0;
        end
        else if (ce_i)
        begin
            sclk_q_r <= sclk_q_nxt;
            cnt_r    <= cnt_nxt;
            rx_r     <= rx_nxt;
            sh_r     <= sh_nxt;
            dout_r   <= dout_nxt;
            stb_r    <= stb_nxt;
            cmd_r    <= cmd_nxt;
            done_r   <= done_nxt;
        end
    end

    assign cmd_stb_o    = stb_r;
    assign cmd_o        = cmd_r;
    assign frame_done_o = done_r;
    assign dout_o       = dout_r;
endmodule : fsr_spi

// *** fsr_fault_status.sv ***
// fault latching, readback and interrupt top level
`timescale 1ns/1ps
module fsr_fault_status #(
    parameter int FILT_CNT_W  = fsr_pkg::FILT_CNT_W,
    parameter int FILT_CYCLES = fsr_pkg::FILT_CYC
) (
    input  wire logic                        clock_i,
    input  wire logic                        rst_n_i,
    input  wire logic                        ce_i,
    input  wire logic                        spi_cs_n_i,
    input  wire logic                        spi_sclk_i,
    input  wire logic                        spi_din_i,
    output logic                             spi_dout_o,
    input  wire logic [fsr_pkg::DATA_W-1:0]  cfg_word_i,
    input  wire logic                        output_current_over_i,
    input  wire logic                        output_voltage_at_rail_i,
    input  wire logic                        overtemp_i,
    input  wire logic                        brownout_i,
    output logic                             fault_n_o,
    output logic                             fault_oe_o
);
    localparam int NF = fsr_pkg::NUM_FLT;
    localparam int DW = fsr_pkg::DATA_W;

    logic [NF-1:0]   raw;
    logic [NF-1:0]   cond;
    logic [NF-1:0]   fire;
    logic [NF-1:0]   lat_r, lat_nxt;
    logic [NF-1:0]   rep_r, rep_nxt;
    logic            inter_r, inter_nxt;
    logic            irq_r, irq_nxt;
    logic            pin_r;
    logic [DW-1:0]   snap_r, snap_nxt;
    logic            rd_err_r, rd_err_nxt;
    fsr_pkg::fsr_rd_state_t st_r, st_nxt;
    logic [DW-1:0]   err_word;
    logic [DW-1:0]   ld_data;
    logic            cmd_stb;
    logic [2:0]      cmd;
    logic            frame_done;
    logic            rd_done;
    logic [NF-1:0]   seen;
    logic            seen_any;

    // open load only counts while no short is present
    assign raw[fsr_pkg::IDX_SHORT] = output_current_over_i;
    assign raw[fsr_pkg::IDX_OPEN]  = output_voltage_at_rail_i
                                     && !output_current_over_i;
    assign raw[fsr_pkg::IDX_OTEMP] = overtemp_i;
    assign raw[fsr_pkg::IDX_BROWN] = brownout_i;

    // output faults need the persistence filter, others pass
    for (genvar g = 0; g < NF; g++)
    begin : g_flt
        if (fsr_pkg::OUT_FLT_MASK[g])
        begin : g_filt
            fsr_qual #(
                .CNT_W (FILT_CNT_W),
                .LIMIT (FILT_CYCLES)
            ) u_qual (
                .clock_i (clock_i),
                .rst_n_i (rst_n_i),
                .ce_i    (ce_i),
                .raw_i   (raw[g]),
                .hit_o   (cond[g])
            );
        end
        else
        begin : g_pass
            assign cond[g] = raw[g];
        end
    end

    fsr_spi #(
        .FRAME_BITS (fsr_pkg::FRAME_BITS),
        .DATA_W     (DW),
        .CMD_AT     (fsr_pkg::CMD_AT)
    ) u_spi (
        .clock_i      (clock_i),
        .rst_n_i      (rst_n_i),
        .ce_i         (ce_i),
        .cs_n_i       (spi_cs_n_i),
        .sclk_i       (spi_sclk_i),
        .din_i        (spi_din_i),
        .ld_data_i    (ld_data),
        .cmd_stb_o    (cmd_stb),
        .cmd_o        (cmd),
        .frame_done_o (frame_done),
        .dout_o       (spi_dout_o)
    );

    // status word: intermittent, four flags, reserved zeros
    assign err_word = {inter_r, lat_r, fsr_pkg::RSVD_BITS};

    // readback mux
    always_comb
    begin
        unique case (cmd)
            fsr_pkg::CMD_RD_CFG: ld_data = cfg_word_i;
            fsr_pkg::CMD_RD_ERR: ld_data = err_word;
            default:             ld_data = '0;
        endcase
    end

    assign fire     = cond & ~rep_r;
    assign rd_done  = frame_done && rd_err_r;
    assign seen     = snap_r[fsr_pkg::FLAG_LO +: NF];
    assign seen_any = |snap_r[fsr_pkg::BIT_INTERM:fsr_pkg::FLAG_LO];

    // latching, read sequence and interrupt
    always_comb
    begin
        lat_nxt    = lat_r;
        rep_nxt    = rep_r;
        inter_nxt  = inter_r;
        irq_nxt    = irq_r;
        st_nxt     = st_r;
        snap_nxt   = snap_r;
        rd_err_nxt = rd_err_r;
        if (cmd_stb)
        begin
            rd_err_nxt = (cmd == fsr_pkg::CMD_RD_ERR);
            if (cmd == fsr_pkg::CMD_RD_ERR)
                snap_nxt = err_word;
        end
        if (frame_done)
            rd_err_nxt = 1'b0;
        if (rd_done)
        begin
            rep_nxt = rep_r & seen;
            if (!seen_any)
                st_nxt = fsr_pkg::FSR_IDLE;
            else
            begin
                unique case (st_r)
                    fsr_pkg::FSR_IDLE:
                    begin
                        irq_nxt = 1'b0;
                        st_nxt  = fsr_pkg::FSR_ONE;
                    end
                    fsr_pkg::FSR_ONE:
                    begin
                        lat_nxt   = '0;
                        inter_nxt = 1'b0;
                        st_nxt    = fsr_pkg::FSR_IDLE;
                    end
                    default:
                        st_nxt = fsr_pkg::FSR_IDLE;
                endcase
            end
        end
        // new events win over any clear in the same cycle
        lat_nxt   = lat_nxt | cond;
        inter_nxt = inter_nxt | (|(lat_nxt & ~cond
                                   & fsr_pkg::OUT_FLT_MASK));
        rep_nxt   = rep_nxt | fire;
        irq_nxt   = irq_nxt | (|fire);
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            lat_r    <= '0;
            rep_r    <= '0;
            inter_r  <= 1'b0;
            irq_r    <= 1'b0;
            pin_r    <= 1'b0;
            st_r     <= fsr_pkg::FSR_IDLE;
            snap_r   <= '0;
            rd_err_r <= 1'b0;
        end
        else if (ce_i)
        begin
            lat_r    <= lat_nxt;
            rep_r    <= rep_nxt;
            inter_r  <= inter_nxt;
            irq_r    <= irq_nxt;
            pin_r    <= 1'b0;
            st_r     <= st_nxt;
            snap_r   <= snap_nxt;
            rd_err_r <= rd_err_nxt;
        end
    end

    // open drain: pull low while asserted, else release
    assign fault_n_o  = pin_r;
    assign fault_oe_o = irq_r;

    // checks
    a_irq_on_fire: assert property (@(posedge clock_i)
        disable iff (!rst_n_i) (ce_i && |fire) |=> irq_r)
        else $error("interrupt not raised on new fault");

    a_flag_latched: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        ce_i |=> ((lat_r & $past(cond)) == $past(cond)))
        else $error("present fault not latched");

    a_first_read: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        (ce_i && rd_done && seen_any && st_r == fsr_pkg::FSR_IDLE
         && fire == '0) |=> (!irq_r && st_r == fsr_pkg::FSR_ONE))
        else $error("first read did not release interrupt");

    a_second_clear: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        (ce_i && rd_done && seen_any && st_r == fsr_pkg::FSR_ONE
         && cond == '0) |=> (lat_r == '0 && !inter_r))
        else $error("second read did not clear status");

    a_no_refire: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        (ce_i && !irq_r && (cond & ~rep_r) == '0) |=> !irq_r)
        else $error("interrupt re-raised for reported fault");

    a_interm_src: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        (ce_i && !inter_r) ##1 inter_r
        |-> $past(|(lat_r & fsr_pkg::OUT_FLT_MASK)))
        else $error("intermittent set without output fault");

    a_cfg_read: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        (ce_i && cmd_stb && cmd == fsr_pkg::CMD_RD_CFG)
        |=> (snap_r == $past(snap_r) || !ce_i))
        else $error("config read disturbed status snapshot");

    a_rsvd_zero: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        (ce_i && cmd_stb && cmd == fsr_pkg::CMD_RD_ERR)
        |=> snap_r[fsr_pkg::FLAG_LO-1:0] == '0)
        else $error("reserved status bits not zero");

    a_read_steps: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        (ce_i && !rd_done) |=> $stable(st_r))
        else $error("read state moved without a read");

    a_short_drops: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        (ce_i && !raw[fsr_pkg::IDX_SHORT]) |=> !cond[fsr_pkg::IDX_SHORT])
        else $error("short flag qualified without current");

    a_open_gated: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        (ce_i && output_current_over_i) |=> !cond[fsr_pkg::IDX_OPEN])
        else $error("open load qualified during a short");

    a_otemp_latch: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        (ce_i && overtemp_i) |=> lat_r[fsr_pkg::IDX_OTEMP])
        else $error("overtemperature not latched");

    a_brown_latch: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        (ce_i && brownout_i) |=> lat_r[fsr_pkg::IDX_BROWN])
        else $error("brownout not latched");

    a_cfg_load: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        (cmd_stb && cmd == fsr_pkg::CMD_RD_CFG) |-> ld_data == cfg_word_i)
        else $error("config word not loaded for readback");

    a_rsvd_load: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        (cmd_stb && cmd == fsr_pkg::CMD_RD_ERR)
        |-> ld_data[fsr_pkg::FLAG_LO-1:0] == '0)
        else $error("reserved bits loaded non-zero");

    a_flag_stays: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        (ce_i && !rd_done) |=> ((lat_r & $past(lat_r)) == $past(lat_r)))
        else $error("fault flag dropped without a read");

    a_interm_stays: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        (ce_i && inter_r && !rd_done) |=> inter_r)
        else $error("intermittent flag dropped without a read");

    a_irq_holds: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        (ce_i && irq_r && !rd_done) |=> irq_r)
        else $error("interrupt released without a read");

    a_rep_release: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        (ce_i && rd_done && !seen_any && cond == '0) |=> rep_r == '0)
        else $error("reported marks kept after all-clear read");

    a_pin_level: assert property (@(posedge clock_i)
        disable iff (!rst_n_i)
        !fault_n_o)
        else $error("fault pin data not low");

    c_fire:     cover property (@(posedge clock_i) disable iff (!rst_n_i)
        $rose(irq_r));
    c_cleared:  cover property (@(posedge clock_i) disable iff (!rst_n_i)
        st_r == fsr_pkg::FSR_ONE ##1 st_r == fsr_pkg::FSR_IDLE);
    c_interm:   cover property (@(posedge clock_i) disable iff (!rst_n_i)
        $rose(inter_r));
    c_two_type: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        (rep_r != '0) && (fire != '0));
endmodule : fsr_fault_status

// *** fsr_host_model.sv ***
// host controller model driving the serial readback port
`timescale 1ns/1ps
module fsr_host_model (
    input  wire logic clock_i,
    input  wire logic spi_dout_i,
    output logic      spi_cs_n_o,
    output logic      spi_sclk_o,
    output logic      spi_din_o
);
    initial
    begin
        spi_cs_n_o = 1'b1;
        spi_sclk_o = 1'b0;
        spi_din_o  = 1'b1;
    end

    // one mode 0 frame, msb first; half sets the speed of each sclk phase
    task automatic frame(input logic [2:0] cmd, input int nbits,
                         input int half, output logic [15:0] rx);
        logic [15:0] tx;
        tx = {2'h0, cmd, 11'h000};
        rx = 16'h0000;
        @(negedge clock_i);
        spi_cs_n_o = 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            spi_din_o = tx[15-i];
            repeat (half) @(negedge clock_i);
            rx = {rx[14:0], spi_dout_i};
            spi_sclk_o = 1'b1;
            repeat (half) @(negedge clock_i);
            spi_sclk_o = 1'b0;
        end
        repeat (half) @(negedge clock_i);
        spi_cs_n_o = 1'b1;
        // released data line no longer holds its last value
        spi_din_o = ~spi_din_o;
        repeat (4) @(negedge clock_i);
    endtask : frame
endmodule : fsr_host_model

// *** tb_top.sv ***
// self-checking bench for the fault status readback block
`timescale 1ns/1ps
module tb_top;
    localparam int HALF = 3;
    localparam logic [2:0] RD = fsr_pkg::CMD_RD_ERR;
    logic        clock_i;
    logic        rst_n_i;
    logic        ce_i;
    logic        spi_cs_n;
    logic        spi_sclk;
    logic        spi_din;
    logic        spi_dout;
    logic [9:0]  cfg_word;
    logic        cur_over;
    logic        at_rail;
    logic        overtemp;
    logic        brownout;
    logic        fault_n_o;
    logic        fault_oe_o;
    logic        fault_line;
    int          fail_count;
    int          samples_checked;

    // open-drain pin with pull-up
    assign fault_line = fault_oe_o ? fault_n_o : 1'b1;

    fsr_fault_status #(.FILT_CNT_W(4), .FILT_CYCLES(8)) uut (
        .clock_i                  (clock_i),
        .rst_n_i                  (rst_n_i),
        .ce_i                     (ce_i),
        .spi_cs_n_i               (spi_cs_n),
        .spi_sclk_i               (spi_sclk),
        .spi_din_i                (spi_din),
        .spi_dout_o               (spi_dout),
        .cfg_word_i               (cfg_word),
        .output_current_over_i    (cur_over),
        .output_voltage_at_rail_i (at_rail),
        .overtemp_i               (overtemp),
        .brownout_i               (brownout),
        .fault_n_o                (fault_n_o),
        .fault_oe_o               (fault_oe_o)
    );

    fsr_host_model host (
        .clock_i    (clock_i),
        .spi_dout_i (spi_dout),
        .spi_cs_n_o (spi_cs_n),
        .spi_sclk_o (spi_sclk),
        .spi_din_o  (spi_din)
    );

    initial
    begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: word %h not %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: bit %b not %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clock_i);
    endtask : wait_clk

    // one full frame, word compared
    task automatic rd(input logic [2:0] cmd, input int half,
                      input logic [15:0] exp);
        logic [15:0] rx;
        host.frame(cmd, 16, half, rx);
        chk_word(rx, exp);
    endtask : rd

    // keep reading the status until it reads all clear, six reads at most
    task automatic poll_clear();
        logic [15:0] rx;
        int          n;
        n = 0;
        rx = 16'hFFFF;
        while (rx !== 16'h0000 && n < 6)
        begin
            host.frame(RD, 16, HALF, rx);
            n++;
        end
        chk_word(rx, 16'h0000);
    endtask : poll_clear

    task automatic t_idle();
        chk_bit(fault_line, 1'b1);
        chk_bit(fault_n_o, 1'b0);
        for (int c = 0; c < 8; c++)
            rd(3'(c), HALF, (c == 5) ? {6'h00, cfg_word} : 16'h0000);
        cfg_word = 10'h15A;
        rd(fsr_pkg::CMD_RD_CFG, 6, 16'h015A);
        rd(RD, 6, 16'h0000);
        $display("test idle done");
    endtask : t_idle

    task automatic t_otemp();
        logic [15:0] rx;
        overtemp = 1'b1;
        wait_clk(2);
        chk_bit(fault_line, 1'b0);
        wait_clk(40);
        chk_bit(fault_line, 1'b0);
        host.frame(RD, 10, HALF, rx);
        chk_bit(fault_line, 1'b0);
        rd(RD, HALF, 16'h0040);
        chk_bit(fault_line, 1'b1);
        rd(fsr_pkg::CMD_RD_CFG, HALF, {6'h00, cfg_word});
        rd(RD, HALF, 16'h0040);
        rd(RD, HALF, 16'h0040);
        chk_bit(fault_line, 1'b1);
        overtemp = 1'b0;
        poll_clear();
        overtemp = 1'b1;
        wait_clk(2);
        chk_bit(fault_line, 1'b0);
        overtemp = 1'b0;
        poll_clear();
        $display("test otemp done");
    endtask : t_otemp

    task automatic t_short();
        cur_over = 1'b1;
        wait_clk(6);
        cur_over = 1'b0;
        wait_clk(4);
        chk_bit(fault_line, 1'b1);
        cur_over = 1'b1;
        at_rail = 1'b1;
        wait_clk(14);
        chk_bit(fault_line, 1'b0);
        cur_over = 1'b0;
        at_rail = 1'b0;
        wait_clk(3);
        rd(RD, HALF, 16'h0300);
        rd(RD, HALF, 16'h0300);
        rd(RD, HALF, 16'h0000);
        $display("test short done");
    endtask : t_short

    task automatic t_open();
        at_rail = 1'b1;
        wait_clk(14);
        chk_bit(fault_line, 1'b0);
        rd(RD, HALF, 16'h0080);
        at_rail = 1'b0;
        wait_clk(3);
        rd(RD, HALF, 16'h0280);
        rd(RD, HALF, 16'h0000);
        chk_bit(fault_line, 1'b1);
        $display("test open done");
    endtask : t_open

    task automatic t_diff();
        brownout = 1'b1;
        wait_clk(2);
        chk_bit(fault_line, 1'b0);
        rd(RD, HALF, 16'h0020);
        chk_bit(fault_line, 1'b1);
        overtemp = 1'b1;
        wait_clk(2);
        chk_bit(fault_line, 1'b0);
        rd(RD, HALF, 16'h0060);
        rd(RD, HALF, 16'h0060);
        chk_bit(fault_line, 1'b1);
        brownout = 1'b0;
        overtemp = 1'b0;
        poll_clear();
        $display("test diff done");
    endtask : t_diff

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done

    initial
    begin
        repeat (50000) @(posedge clock_i);
        fail_count++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        test_done();
    end

    initial
    begin
        fail_count = 0;
        samples_checked = 0;
        rst_n_i = 1'b0;
        ce_i = 1'b1;
        cfg_word = 10'h2A5;
        cur_over = 1'b0;
        at_rail = 1'b0;
        overtemp = 1'b0;
        brownout = 1'b0;
        wait_clk(16);
        rst_n_i = 1'b1;
        t_idle();
        t_otemp();
        t_short();
        t_open();
        t_diff();
        test_done();
    end
endmodule : tb_top
